// File: spibr_core.sv
// spi slave with burst register access, packet memories and soft reset
//
// Contract
// - recursive write advances register address per word
// - address pointer wraps from 63 to 3
// - one receive, two transmit 64x16 memories
// - address 1 receive port, 2 selected transmit
// - receive port read advances memory pointer only
// - each read starts at memory word zero
// - report received byte count, checksum included
// - checksum bytes read back swapped
// - first memory read word is a dummy
// - memory overrun sets address error bit 14
// - core access during serial memory access sets bit 13
// - masked interrupt, flags cleared by status read
// - checksum not stored, hardware appends it
// - transmit port write advances memory pointer, starts zero
// - select bit resets to first, steers both paths
// - write to address zero resets core, keeps memories
// - soft reset from header until chip select high
// - header: read bit, six address bits, msb first
// - fewer than 24 edges write nothing; a header alone can still soft reset or clear status
// - sample on rising edge, drive on falling
`timescale 1ns/1ps
`include "spibr_regs.svh"

module spibr_core (
	input wire logic ref_clk, // core clock
	input wire logic rst, // reset, active high; synchronous on ref_clk, asynchronous on the serial side toggles
	input wire logic spi_clk, // serial clock from host
	input wire logic ce_n, // chip select, active low
	input wire logic mosi, // serial data in
	output logic miso, // serial data out
	output logic miso_oe_n, // miso driven while low
	output logic sw_reset, // soft reset to rest of core
	output logic irq, // interrupt request, active high
	output logic tx_mem_sel, // selected transmit memory
	output logic [6:0] tx_frame_len, // frame length incl checksum
	input wire logic rx_wr_en, // receiver writes a word
	input wire logic [5:0] rx_wr_addr, // receiver word address
	input wire logic [15:0] rx_wr_data, // receiver word
	input wire logic rx_wr_crc, // word holds the checksum
	input wire logic rx_frame_done, // receiver frame complete
	input wire logic [6:0] rx_frame_bytes, // receiver byte count
	input wire logic tx_rd_en, // transmitter reads a word
	input wire logic [5:0] tx_rd_addr, // transmitter word address
	output logic [15:0] tx_rd_data // transmitter word, next cycle
);

	// =========================================================
	// memories
	logic [15:0] rx_ram [64];
	logic [15:0] tx_ram [2][64];

	// =========================================================
	// serial side, runs on spi_clk
	logic [15:0] sh_in;
	logic [3:0] bit_cnt;
	logic hdr_done;
	logic [7:0] hdr_byte;
	spibr_pkg::spibr_word_t word_data;
	logic hdr_tgl;
	logic word_tgl;
	logic [14:0] sh_out;
	spibr_pkg::spibr_word_t rd_word;

	wire hdr_fire = !hdr_done && (bit_cnt == `SPIBR_HDR_LAST);
	wire word_fire = hdr_done && (bit_cnt == `SPIBR_WORD_LAST);
	wire [15:0] shifted = {sh_in[14:0], mosi};

	// frame counters clear while chip select is high
	always_ff @(posedge spi_clk or posedge ce_n) begin
		if (ce_n) begin
			bit_cnt <= 4'h0;
			hdr_done <= 1'b0;
			sh_in <= 16'h0000;
		end else begin
			sh_in <= shifted;
			bit_cnt <= (hdr_fire || word_fire) ? 4'h0 : bit_cnt + 4'h1;
			if (hdr_fire)
				hdr_done <= 1'b1;
		end
	end

	// data holds stable for a whole word while the core picks it up
	always_ff @(posedge spi_clk) begin
		if (hdr_fire)
			hdr_byte <= shifted[7:0];
		if (word_fire)
			word_data <= shifted;
	end

	// toggles survive frames so the clock stopping cannot fake events
	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			hdr_tgl <= 1'b0;
			word_tgl <= 1'b0;
		end else begin
			if (hdr_fire)
				hdr_tgl <= ~hdr_tgl;
			if (word_fire)
				word_tgl <= ~word_tgl;
		end
	end

	// rd_word crosses without a handshake: the core updates it within
	// about four core cycles of the last rising edge of a header or word,
	// so the serial clock high phase must cover that before the falling
	// edge loads it; a shorter high phase shifts out a stale word
	always_ff @(negedge spi_clk or posedge ce_n) begin
		if (ce_n) begin
			miso <= 1'b0;
			miso_oe_n <= 1'b1;
			sh_out <= 15'h0000;
		end else begin
			miso_oe_n <= 1'b0;
			if (hdr_done && bit_cnt == 4'h0)
				{miso, sh_out} <= rd_word;
			else
				{miso, sh_out} <= {sh_out, 1'b0};
		end
	end

	// =========================================================
	// crossings into ref_clk
	// three flops per crossing; an event counts once the last two agree
	logic [2:0] ce_sync;
	logic [2:0] hdr_sync;
	logic [2:0] word_sync;
	logic ce_idle;
	logic hdr_last;
	logic word_last;

	wire hdr_stable = hdr_sync[1] == hdr_sync[2];
	wire word_stable = word_sync[1] == word_sync[2];
	wire hdr_ev = hdr_stable && (hdr_sync[2] != hdr_last);
	wire word_ev = word_stable && (word_sync[2] != word_last);

	always_ff @(posedge ref_clk) begin
		ce_sync <= {ce_sync[1:0], ce_n};
		hdr_sync <= {hdr_sync[1:0], hdr_tgl};
		word_sync <= {word_sync[1:0], word_tgl};
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ce_idle <= 1'b1;
			hdr_last <= 1'b0;
			word_last <= 1'b0;
		end else begin
			if (ce_sync[1] == ce_sync[2])
				ce_idle <= ce_sync[2];
			if (hdr_stable)
				hdr_last <= hdr_sync[2];
			if (word_stable)
				word_last <= word_sync[2];
		end
	end

	// =========================================================
	// soft reset
	// a read of address zero never asserts it
	logic soft_rst;
	wire core_rst = rst || soft_rst;
	wire hdr_write = !hdr_byte[`SPIBR_HDR_RW_BIT];
	wire [5:0] hdr_addr = hdr_byte[5:0];

	always_ff @(posedge ref_clk) begin
		if (rst)
			soft_rst <= 1'b0;
		else if (hdr_ev && hdr_write && hdr_addr == `SPIBR_ADDR_SWRST)
			soft_rst <= 1'b1;
		else if (ce_idle)
			soft_rst <= 1'b0;
	end

	// =========================================================
	// registers
	logic txsel;
	logic [6:0] txlen;
	logic msk_addr;
	logic msk_arb;
	logic err_addr;
	logic err_arb;
	logic [6:0] rx_count;

	function automatic spibr_pkg::spibr_word_t reg_read(
		input logic [5:0] a
	);
		spibr_pkg::spibr_word_t v;
		v = 16'h0000;
		case (a)
			`SPIBR_ADDR_TXCTL: begin
				v[`SPIBR_TXSEL_BIT] = txsel;
				v[`SPIBR_LEN_MSB:0] = txlen;
			end
			`SPIBR_ADDR_MASK: begin
				v[`SPIBR_MSK_ADDR_BIT] = msk_addr;
				v[`SPIBR_MSK_ARB_BIT] = msk_arb;
			end
			`SPIBR_ADDR_STAT: begin
				v[`SPIBR_ERR_ADDR_BIT] = err_addr;
				v[`SPIBR_ERR_ARB_BIT] = err_arb;
			end
			`SPIBR_ADDR_RXCNT: v[6:0] = rx_count;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : reg_read

	function automatic logic [5:0] next_addr(input logic [5:0] a);
		return (a == `SPIBR_ADDR_TOP) ? `SPIBR_ADDR_WRAP : a + 6'h01;
	endfunction : next_addr

	function automatic spibr_pkg::spibr_acc_t kind_of(
		input logic [5:0] a
	);
		case (a)
			`SPIBR_ADDR_RXRAM: return spibr_pkg::acc_rxram;
			`SPIBR_ADDR_TXRAM: return spibr_pkg::acc_txram;
			default: return spibr_pkg::acc_reg;
		endcase
	endfunction : kind_of

	// =========================================================
	// access session
	// the register pointer wraps past the memory ports and soft reset
	logic acc_rw;
	logic [5:0] acc_addr;
	spibr_pkg::spibr_acc_t acc_kind;
	logic [6:0] ram_ptr;
	logic in_frame;

	wire acc_ram = acc_kind != spibr_pkg::acc_reg;
	wire [5:0] nxt = next_addr(acc_addr);
	wire ram_full = ram_ptr == `SPIBR_RAM_WORDS;
	wire ram_over = ram_ptr == `SPIBR_RAM_OVER;
	wire wr_word = word_ev && !acc_rw;
	wire rd_word_ev = word_ev && acc_rw;
	wire ram_wr = wr_word && acc_ram && !ram_full;
	wire reg_wr = wr_word && !acc_ram;
	wire [5:0] ptr6 = ram_ptr[5:0];
	wire [15:0] ram_q = (acc_kind == spibr_pkg::acc_rxram) ?
		rx_ram[ptr6] : tx_ram[txsel][ptr6];
	wire ram_session = in_frame && !ce_idle && acc_ram;
	wire core_ram = rx_wr_en || tx_rd_en;

	wire set_addr_err = word_ev && acc_ram &&
		(acc_rw ? ram_over : ram_full);
	// a core memory access during a memory frame is flagged, not stalled
	wire set_arb_err = core_ram && ram_session;
	wire stat_clr = (hdr_ev && !hdr_write &&
		hdr_addr == `SPIBR_ADDR_STAT) ||
		(rd_word_ev && !acc_ram && nxt == `SPIBR_ADDR_STAT);

	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			acc_rw <= 1'b0;
			acc_addr <= `SPIBR_ADDR_SWRST;
			acc_kind <= spibr_pkg::acc_reg;
			ram_ptr <= 7'h00;
			in_frame <= 1'b0;
		end else if (hdr_ev) begin
			acc_rw <= !hdr_write;
			acc_addr <= hdr_addr;
			acc_kind <= kind_of(hdr_addr);
			ram_ptr <= 7'h00;
			in_frame <= 1'b1;
		end else if (word_ev) begin
			if (!acc_ram)
				acc_addr <= nxt;
			else if (acc_rw ? !ram_over : !ram_full)
				ram_ptr <= ram_ptr + 7'h01;
		end else if (ce_idle) begin
			in_frame <= 1'b0;
		end
	end

	// read word for the next data word on miso
	always_ff @(posedge ref_clk) begin
		if (core_rst)
			rd_word <= 16'h0000;
		else if (hdr_ev)
			rd_word <= (kind_of(hdr_addr) == spibr_pkg::acc_reg) ?
				reg_read(hdr_addr) : 16'h0000;
		else if (rd_word_ev && !acc_ram)
			rd_word <= reg_read(nxt);
		else if (rd_word_ev)
			rd_word <= (ram_full || ram_over) ? 16'h0000 : ram_q;
	end

	// =========================================================
	// register file
	// only the implemented bits of each reset image are kept
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			txsel <= 1'(`SPIBR_TXCTL_RST >> `SPIBR_TXSEL_BIT);
			txlen <= 7'(`SPIBR_TXCTL_RST);
			msk_addr <= 1'(`SPIBR_MASK_RST >> `SPIBR_MSK_ADDR_BIT);
			msk_arb <= 1'(`SPIBR_MASK_RST >> `SPIBR_MSK_ARB_BIT);
		end else if (reg_wr && acc_addr == `SPIBR_ADDR_TXCTL) begin
			txsel <= word_data[`SPIBR_TXSEL_BIT];
			txlen <= word_data[`SPIBR_LEN_MSB:0];
		end else if (reg_wr && acc_addr == `SPIBR_ADDR_MASK) begin
			msk_addr <= word_data[`SPIBR_MSK_ADDR_BIT];
			msk_arb <= word_data[`SPIBR_MSK_ARB_BIT];
		end
	end

	// set wins over the read clear so no error is lost
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			err_addr <= 1'(`SPIBR_STAT_RST >> `SPIBR_ERR_ADDR_BIT);
			err_arb <= 1'(`SPIBR_STAT_RST >> `SPIBR_ERR_ARB_BIT);
		end else begin
			err_addr <= set_addr_err || (err_addr && !stat_clr);
			err_arb <= set_arb_err || (err_arb && !stat_clr);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (core_rst)
			rx_count <= `SPIBR_RXCNT_RST;
		else if (rx_frame_done)
			rx_count <= rx_frame_bytes;
	end

	// =========================================================
	// memory ports, contents kept through any reset
	wire [15:0] rx_core_word = rx_wr_crc ?
		{rx_wr_data[7:0], rx_wr_data[15:8]} : rx_wr_data;

	// the receiver wins a collision; the serial word is lost and flagged
	always_ff @(posedge ref_clk) begin
		if (rx_wr_en)
			rx_ram[rx_wr_addr] <= rx_core_word;
		else if (ram_wr && acc_kind == spibr_pkg::acc_rxram)
			rx_ram[ptr6] <= word_data;
	end

	always_ff @(posedge ref_clk) begin
		if (ram_wr && acc_kind == spibr_pkg::acc_txram)
			tx_ram[txsel][ptr6] <= word_data;
	end

	always_ff @(posedge ref_clk) begin
		if (core_rst)
			tx_rd_data <= 16'h0000;
		else if (tx_rd_en)
			tx_rd_data <= tx_ram[txsel][tx_rd_addr];
	end

	// =========================================================
	// outputs
	always_ff @(posedge ref_clk) begin
		if (core_rst)
			irq <= 1'b0;
		else
			irq <= (err_addr && msk_addr) || (err_arb && msk_arb);
	end

	// checksum is appended by the modulator, so length covers two more
	assign tx_mem_sel = txsel;
	assign tx_frame_len = txlen;
	assign sw_reset = soft_rst;

endmodule : spibr_core

// File: spibr_regs.svh
// register offsets, field positions, reset values and counts of the spi block
`ifndef SPIBR_REGS_SVH
`define SPIBR_REGS_SVH

`define SPIBR_ADDR_SWRST 6'h00
`define SPIBR_ADDR_RXRAM 6'h01
`define SPIBR_ADDR_TXRAM 6'h02
`define SPIBR_ADDR_TXCTL 6'h03
`define SPIBR_ADDR_MASK 6'h05
`define SPIBR_ADDR_STAT 6'h24
`define SPIBR_ADDR_RXCNT 6'h2d
`define SPIBR_ADDR_TOP 6'h3f
`define SPIBR_ADDR_WRAP 6'h03

`define SPIBR_HDR_RW_BIT 7
`define SPIBR_TXSEL_BIT 15
`define SPIBR_LEN_MSB 6
`define SPIBR_ERR_ADDR_BIT 14
`define SPIBR_ERR_ARB_BIT 13
`define SPIBR_MSK_ADDR_BIT 12
`define SPIBR_MSK_ARB_BIT 11

`define SPIBR_TXCTL_RST 16'h0000
`define SPIBR_MASK_RST 16'h0000
`define SPIBR_STAT_RST 16'h0000
`define SPIBR_RXCNT_RST 7'h00

`define SPIBR_RAM_WORDS 7'h40
`define SPIBR_RAM_OVER 7'h41
`define SPIBR_HDR_LAST 4'h7
`define SPIBR_WORD_LAST 4'hf

`endif

// File: spibr_pkg.sv
// types shared by the spi burst and packet memory block
package spibr_pkg;
	typedef enum logic [1:0] {
		acc_reg,
		acc_rxram,
		acc_txram
	} spibr_acc_t;
	typedef logic [15:0] spibr_word_t;
endpackage : spibr_pkg

// File: spibr_core_checker.sv
// port checker for the spi burst and packet memory block
`timescale 1ns/1ps
// ==========
// checker
module spibr_core_checker (
	input wire logic ref_clk, // core clock
	input wire logic rst, // reset, active high
	input wire logic ce_n, // chip select, active low
	input wire logic miso, // serial out
	input wire logic miso_oe_n, // miso driven while low
	input wire logic sw_reset, // soft reset level
	input wire logic irq, // interrupt request
	input wire logic tx_mem_sel, // transmit memory select
	input wire logic [6:0] tx_frame_len // frame length
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// idle long enough that a late synchronised write has landed
	sequence s_idle;
		ce_n [*8] ##1 ce_n;
	endsequence
	chk_reset_outs: assert property (disable iff (1'h0)
		rst |=> !irq && !tx_mem_sel && !sw_reset && tx_frame_len == 7'h00)
		else $error("outputs not cleared by reset");
	chk_miso_released: assert property (ce_n && $past(ce_n) |->
		miso_oe_n && !miso)
		else $error("miso driven while deselected");
	chk_swrst_in_frame: assert property ($rose(sw_reset) |-> !ce_n)
		else $error("soft reset outside a frame");
	chk_swrst_release: assert property (
		$rose(ce_n) |-> ##[0:8] !sw_reset)
		else $error("soft reset held after deselect");
	chk_swrst_clears: assert property (sw_reset |=>
		!tx_mem_sel && !irq && tx_frame_len == 7'h00)
		else $error("soft reset left fields set");
	chk_len_idle: assert property (s_idle |-> $stable(tx_frame_len))
		else $error("frame length moved while idle");
	chk_sel_idle: assert property (s_idle |-> $stable(tx_mem_sel))
		else $error("memory select moved while idle");
	chk_irq_idle: assert property (s_idle |-> $stable(irq))
		else $error("interrupt moved while idle");
endmodule : spibr_core_checker

bind spibr_core spibr_core_checker u_spibr_core_checker (.ref_clk, .rst,
	.ce_n, .miso, .miso_oe_n, .sw_reset, .irq, .tx_mem_sel, .tx_frame_len);

// File: spibr_host.sv
// host serial master model for the spi burst block
`timescale 1ns/1ps
// ==========
// host model
module spibr_host (
	output logic spi_clk, // serial clock, still between frames
	output logic ce_n, // chip select, active low
	output logic mosi, // serial data to device
	input wire logic miso, // serial data from device
	input wire logic miso_oe_n // device drives miso while low
);
	initial begin
		spi_clk = 1'h0;
		ce_n = 1'h0;
		mosi = 1'h0;
		// a rising select clears the serial counters before any frame
		#1;
		ce_n = 1'h1;
	end
	// odd offset keeps the link out of phase with the core clock
	task automatic open_frame;
		ce_n = 1'h0;
		#50.3;
	endtask : open_frame
	// 64 ns period; high phase 50 ns so the next read word is loaded
	task automatic shift(input int n, input logic [15:0] d,
		output logic [15:0] q);
		q = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#14;
			spi_clk = 1'h1;
			q[i] = miso;
			#50;
			spi_clk = 1'h0;
		end
	endtask : shift
	task automatic close_frame;
		#50;
		ce_n = 1'h1;
		mosi = ~mosi;
		#120;
	endtask : close_frame
endmodule : spibr_host

// File: spibr_core_tb_top.sv
// self-checking bench for the spi burst and packet memory block
`timescale 1ns/1ps
// ==========
// bench
module spibr_core_tb_top;
	logic ref_clk = 1'h0;
	logic rst = 1'h0;
	logic rx_wr_en = 1'h0;
	logic [5:0] rx_wr_addr = 6'h00;
	logic [15:0] rx_wr_data = 16'h0000;
	logic rx_wr_crc = 1'h0;
	logic rx_frame_done = 1'h0;
	logic [6:0] rx_frame_bytes = 7'h00;
	logic tx_rd_en = 1'h0;
	logic [5:0] tx_rd_addr = 6'h00;
	logic spi_clk, ce_n, mosi, miso, miso_oe_n, sw_reset, irq, tx_mem_sel;
	logic [6:0] tx_frame_len;
	logic [15:0] tx_rd_data;
	logic [15:0] wbuf [0:3];
	logic [15:0] rbuf [0:65];
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 ref_clk = ~ref_clk;
	spibr_core u_spibr_core (.ref_clk, .rst, .spi_clk, .ce_n, .mosi, .miso,
		.miso_oe_n, .sw_reset, .irq, .tx_mem_sel, .tx_frame_len, .rx_wr_en,
		.rx_wr_addr, .rx_wr_data, .rx_wr_crc, .rx_frame_done,
		.rx_frame_bytes, .tx_rd_en, .tx_rd_addr, .tx_rd_data);
	spibr_host u_spibr_host (.spi_clk, .ce_n, .mosi, .miso, .miso_oe_n);
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			stop_test();
		end
	end
	task automatic check(input string n, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask : check
	task automatic frame(input logic [7:0] hdr, input int n);
		logic [15:0] q;
		u_spibr_host.open_frame();
		u_spibr_host.shift(8, {8'h00, hdr}, q);
		for (int i = 0; i < n; i++) begin
			u_spibr_host.shift(16, wbuf[i % 4], q);
			rbuf[i] = q;
		end
		u_spibr_host.close_frame();
	endtask : frame
	task automatic txrd(input logic [5:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		tx_rd_en = 1'h1;
		tx_rd_addr = a;
		@(negedge ref_clk);
		tx_rd_en = 1'h0;
		@(negedge ref_clk);
		check("tx_rd_data", e, tx_rd_data);
	endtask : txrd
	task automatic rxwr(input logic [5:0] a, input logic [15:0] d,
		input logic c);
		@(negedge ref_clk);
		rx_wr_en = 1'h1;
		rx_wr_addr = a;
		rx_wr_data = d;
		rx_wr_crc = c;
		@(negedge ref_clk);
		rx_wr_en = 1'h0;
	endtask : rxwr
	task automatic t_reset_values;
		frame(8'h83, 2);
		check("txctl", 16'h0000, rbuf[0]);
		check("tx_mem_sel", 16'h0000, 16'(tx_mem_sel));
	endtask : t_reset_values
	task automatic t_wrap_write;
		wbuf = '{16'h1111, 16'h807f, 16'h0000, 16'h1800};
		frame(8'h3f, 4);
		check("tx_frame_len", 16'h007f, 16'(tx_frame_len));
		check("tx_mem_sel", 16'h0001, 16'(tx_mem_sel));
		frame(8'h85, 1);
		check("mask", 16'h1800, rbuf[0]);
	endtask : t_wrap_write
	task automatic t_tx_mem;
		wbuf = '{16'ha001, 16'ha002, 16'ha003, 16'ha004};
		frame(8'h02, 4);
		txrd(6'h00, 16'ha001);
		txrd(6'h03, 16'ha004);
		wbuf[0] = 16'h0000;
		frame(8'h03, 1);
		wbuf[0] = 16'h5a5a;
		frame(8'h02, 1);
		txrd(6'h00, 16'h5a5a);
		wbuf[0] = 16'h8000;
		frame(8'h03, 1);
		txrd(6'h00, 16'ha001);
	endtask : t_tx_mem
	task automatic t_rx_read;
		rxwr(6'h00, 16'hbeef, 1'h0);
		rxwr(6'h01, 16'h1234, 1'h1);
		@(negedge ref_clk);
		rx_frame_done = 1'h1;
		rx_frame_bytes = 7'h04;
		@(negedge ref_clk);
		rx_frame_done = 1'h0;
		frame(8'h81, 3);
		check("dummy", 16'h0000, rbuf[0]);
		check("rx word0", 16'hbeef, rbuf[1]);
		check("rx crc", 16'h3412, rbuf[2]);
		frame(8'h81, 2);
		check("rx restart", 16'hbeef, rbuf[1]);
		frame(8'had, 1);
		check("rx count", 16'h0004, rbuf[0]);
	endtask : t_rx_read
	task automatic t_overrun;
		frame(8'h81, 66);
		check("irq", 16'h0001, 16'(irq));
		frame(8'ha4, 1);
		check("status", 16'h4000, rbuf[0]);
		check("irq", 16'h0000, 16'(irq));
		frame(8'ha4, 1);
		check("status", 16'h0000, rbuf[0]);
		frame(8'h02, 65);
		check("irq", 16'h0001, 16'(irq));
		frame(8'ha4, 1);
		check("status", 16'h4000, rbuf[0]);
	endtask : t_overrun
	task automatic t_arbit;
		fork
			frame(8'h81, 2);
			begin
				// inside the memory session, after the header event
				#1000;
				rxwr(6'h05, 16'h0055, 1'h0);
			end
		join
		check("irq", 16'h0001, 16'(irq));
		frame(8'ha4, 1);
		check("status", 16'h2000, rbuf[0]);
	endtask : t_arbit
	task automatic t_short;
		logic [15:0] q;
		u_spibr_host.open_frame();
		u_spibr_host.shift(8, 16'h0003, q);
		u_spibr_host.shift(15, 16'h7fff, q);
		u_spibr_host.close_frame();
		check("tx_frame_len", 16'h0000, 16'(tx_frame_len));
		u_spibr_host.open_frame();
		u_spibr_host.shift(8, 16'h003f, q);
		u_spibr_host.shift(16, 16'h1111, q);
		u_spibr_host.shift(15, 16'h7fff, q);
		u_spibr_host.close_frame();
		check("tx_frame_len", 16'h0000, 16'(tx_frame_len));
	endtask : t_short
	task automatic t_soft_reset;
		logic [15:0] q;
		wbuf[0] = 16'h0033;
		frame(8'h03, 1);
		check("tx_frame_len", 16'h0033, 16'(tx_frame_len));
		u_spibr_host.open_frame();
		u_spibr_host.shift(8, 16'h0000, q);
		#200;
		check("sw_reset", 16'h0001, 16'(sw_reset));
		u_spibr_host.close_frame();
		check("sw_reset", 16'h0000, 16'(sw_reset));
		check("tx_frame_len", 16'h0000, 16'(tx_frame_len));
		txrd(6'h00, 16'h5a5a);
		frame(8'h85, 1);
		check("mask", 16'h0000, rbuf[0]);
	endtask : t_soft_reset
	initial begin
		// a rising reset is needed to clear the serial side toggles
		@(negedge ref_clk);
		rst = 1'h1;
		repeat (20) @(negedge ref_clk);
		rst = 1'h0;
		repeat (4) @(negedge ref_clk);
		t_reset_values();
		t_wrap_write();
		t_tx_mem();
		t_rx_read();
		t_overrun();
		t_arbit();
		t_short();
		t_soft_reset();
		stop_test();
	end
endmodule : spibr_core_tb_top
